//--- src/dram_mode_regs_7_to_12.sv
// Purpose: mode register bank at addresses 07h..0Ch
// Assumes: one command per cycle from the controller, same clock
// Notes:   read data is registered, valid one cycle after the read
`timescale 1ns/10ps
`default_nettype none
module dram_mode_regs_7_to_12
  import mode_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_ID_TWO = 8'h00  // arbitrary value
)(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // mode register commands
  input  wire logic       mr_write_i,
  input  wire logic       mr_read_i,
  input  wire logic [5:0] mr_addr_i,
  input  wire logic [7:0] mr_wdata_i,
  // set-point selects from the next register
  input  wire logic       write_set_point_sel_i,
  input  wire logic       operating_set_point_sel_i,
  // calibration pin strap, high when grounded
  input  wire logic       cal_pin_grounded_i,
  // read answer
  output logic [7:0]      mr_rdata_o,
  output logic            mr_rvalid_o,
  // active settings
  output logic [2:0]      data_bus_termination_o,
  output logic [2:0]      cmd_bus_termination_o,
  output logic [5:0]      cmd_bus_reference_level_o,
  output logic            cmd_reference_range_sel_o,
  // calibration default restore pulse and default-only flag
  output logic            calibration_default_restore_o,
  output logic            cal_default_only_o
);

  logic       rst_sync_q1;     // reset release stage 1
  logic       rst_sync_q2;     // reset release stage 2
  logic       strap_sync_q1;   // strap pin stage 1
  logic       strap_sync_q2;   // strap pin stage 2
  logic       strap_sync_q3;   // strap pin stage 3
  logic       strap_q;         // caught strap
  logic       strap_taken_q;   // strap caught flag
  mr_cmd_t    cmd;             // command carrier
  set_point_t copy0;           // set point 0
  set_point_t copy1;           // set point 1
  set_point_t wsel_copy;       // write-selected copy
  set_point_t op_copy;         // operating copy
  logic [7:0] rdata_d;         // read mux
  logic [7:0] rdata_q;         // registered read data
  logic       rvalid_q;        // read data valid
  logic       restore_q;       // calibration restore pulse

  // reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q1 <= 1'b0;
      rst_sync_q2 <= 1'b0;
    end else begin
      rst_sync_q1 <= 1'b1;
      rst_sync_q2 <= rst_sync_q1;
    end
  end

  // bundle command
  assign cmd = '{write: mr_write_i, read: mr_read_i, addr: mr_addr_i, data: mr_wdata_i};

  // strap pin synchroniser, free running so it is full when reset lifts
  always_ff @(posedge clk_i) begin
    strap_sync_q1 <= cal_pin_grounded_i;
    strap_sync_q2 <= strap_sync_q1;
    strap_sync_q3 <= strap_sync_q2;
  end

  // strap is fixed after power: catch once after release, when stages agree
  always_ff @(posedge clk_i or negedge rst_sync_q2) begin
    if (!rst_sync_q2) begin
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q && strap_sync_q2 == strap_sync_q3) begin
      strap_q       <= strap_sync_q3;
      strap_taken_q <= 1'b1;
    end
  end

  // per-set-point storage
  set_point_bank u_bank (
    .clk_i     (clk_i),
    .rst_n_i   (rst_sync_q2),
    .sel_i     (write_set_point_sel_i),
    .term_we_i (cmd.write && cmd.addr == ADDR_TERMINATION_SEL),
    .ref_we_i  (cmd.write && cmd.addr == ADDR_CMD_BUS_REF),
    .wdata_i   (cmd.data),
    .copy0_o   (copy0),
    .copy1_o   (copy1)
  );

  // copy selection
  assign wsel_copy = write_set_point_sel_i ? copy1 : copy0;
  assign op_copy   = operating_set_point_sel_i ? copy1 : copy0;

  // active settings from the operating copy
  assign data_bus_termination_o    = op_copy.data_term;
  assign cmd_bus_termination_o     = op_copy.cmd_term;
  assign cmd_bus_reference_level_o = op_copy.ref_level;
  assign cmd_reference_range_sel_o = op_copy.ref_range;

  // read mux; write-only addresses and others read zero
  always_comb begin
    rdata_d = 8'h00;
    case (cmd.addr)
      ADDR_REVISION_ID_TWO: rdata_d = REVISION_ID_TWO;
      ADDR_DEVICE_ORG: begin
        rdata_d[ORG_TYPE_LSB +: 2]    = ORG_TYPE_PREFETCH16;
        rdata_d[ORG_DENSITY_LSB +: 4] = ORG_DENSITY_4GB_DUAL;
        rdata_d[ORG_WIDTH_LSB +: 2]   = ORG_WIDTH_X16;
      end
      ADDR_CMD_BUS_REF: begin
        rdata_d[REF_LEVEL_LSB +: 6] = wsel_copy.ref_level;
        rdata_d[REF_RANGE_BIT]      = wsel_copy.ref_range;
      end
      default: rdata_d = 8'h00;
    endcase
  end

  // registered read answer
  always_ff @(posedge clk_i or negedge rst_sync_q2) begin
    if (!rst_sync_q2) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cmd.read;
      rdata_q  <= cmd.read ? rdata_d : 8'h00;
    end
  end

  // calibration restore pulse, blocked by grounded pin
  always_ff @(posedge clk_i or negedge rst_sync_q2) begin
    if (!rst_sync_q2) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= cmd.write && cmd.addr == ADDR_CAL_RESET_CTRL
                   && cmd.data[CAL_RESET_BIT] && !strap_q;
    end
  end

  assign mr_rdata_o                    = rdata_q;
  assign mr_rvalid_o                   = rvalid_q;
  assign calibration_default_restore_o = restore_q;
  assign cal_default_only_o            = strap_q;

  // assertions
  property p_restore;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.write && cmd.addr == ADDR_CAL_RESET_CTRL && cmd.data[CAL_RESET_BIT] && !strap_q)
        |=> calibration_default_restore_o;
  endproperty
  a_restore: assert property (p_restore) else $error("restore pulse missing");

  property p_ground_block;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      $past(strap_q) |-> !calibration_default_restore_o;
  endproperty
  a_ground_block: assert property (p_ground_block) else $error("restore while grounded");

  property p_rev;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.read && cmd.addr == ADDR_REVISION_ID_TWO) |=> mr_rdata_o == REVISION_ID_TWO;
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");

  property p_org;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.read && cmd.addr == ADDR_DEVICE_ORG) |=> mr_rdata_o == 8'h00 && mr_rvalid_o;
  endproperty
  a_org: assert property (p_org) else $error("organisation read wrong");

  property p_density;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.read && cmd.addr == ADDR_DEVICE_ORG) |=> mr_rdata_o[5:2] == ORG_DENSITY_4GB_DUAL;
  endproperty
  a_density: assert property (p_density) else $error("density code wrong");

  sequence s_ref_write;
    cmd.write && cmd.addr == ADDR_CMD_BUS_REF && write_set_point_sel_i == operating_set_point_sel_i;
  endsequence
  sequence s_ref_hold;
    !cmd.write && $stable(operating_set_point_sel_i);
  endsequence
  property p_ref_write;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      s_ref_write ##1 s_ref_hold |-> cmd_bus_reference_level_o == $past(mr_wdata_i[5:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("level not applied");

  property p_range;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      s_ref_write ##1 s_ref_hold |-> cmd_reference_range_sel_o == $past(mr_wdata_i[6]);
  endproperty
  a_range: assert property (p_range) else $error("range not applied");

  property p_inactive;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.write && write_set_point_sel_i != operating_set_point_sel_i
       ##1 $stable(operating_set_point_sel_i)) |-> $stable(data_bus_termination_o)
       && $stable(cmd_bus_reference_level_o);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive write changed operation");

  property p_read_zero;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.read && cmd.addr == ADDR_CMD_BUS_REF) |=> !mr_rdata_o[7];
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("reserved bit set");

  property p_term;
    @(posedge clk_i) disable iff (!rst_sync_q2)
      (cmd.write && cmd.addr == ADDR_TERMINATION_SEL && write_set_point_sel_i == operating_set_point_sel_i
       ##1 (!cmd.write && $stable(operating_set_point_sel_i)))
        |-> data_bus_termination_o == $past(mr_wdata_i[2:0]) && cmd_bus_termination_o == $past(mr_wdata_i[6:4]);
  endproperty
  a_term: assert property (p_term) else $error("termination not applied");

endmodule // dram_mode_regs_7_to_12
`default_nettype wire

//--- src/mode_regs_pkg.sv
// Purpose: shared constants and carriers for the mode register bank 07h..0Ch
// Assumes: 6-bit mode address, 8-bit operand
// Notes:   set-point copies are indexed by the set-point select bits
package mode_regs_pkg;

  // mode addresses
  localparam logic [5:0] ADDR_REVISION_ID_TWO  = 6'h07;
  localparam logic [5:0] ADDR_DEVICE_ORG       = 6'h08;
  localparam logic [5:0] ADDR_CAL_RESET_CTRL   = 6'h0a;
  localparam logic [5:0] ADDR_TERMINATION_SEL  = 6'h0b;
  localparam logic [5:0] ADDR_CMD_BUS_REF      = 6'h0c;

  // organisation report fields
  localparam int         ORG_TYPE_LSB          = 0;
  localparam int         ORG_DENSITY_LSB       = 2;
  localparam int         ORG_WIDTH_LSB         = 6;
  localparam logic [1:0] ORG_TYPE_PREFETCH16   = 2'h0;
  localparam logic [3:0] ORG_DENSITY_4GB_DUAL  = 4'h0;
  localparam logic [1:0] ORG_WIDTH_X16         = 2'h0;

  // calibration reset control field
  localparam int         CAL_RESET_BIT         = 0;

  // termination select fields
  localparam int         DATA_TERM_LSB         = 0;
  localparam int         CMD_TERM_LSB          = 4;
  localparam logic [2:0] TERM_RESET            = 3'h0;
  localparam logic [2:0] TERM_RESERVED         = 3'h7;

  // command-bus reference fields
  localparam int         REF_LEVEL_LSB         = 0;
  localparam int         REF_RANGE_BIT         = 6;
  localparam logic [5:0] REF_LEVEL_RESET       = 6'h0d;
  localparam logic [5:0] REF_LEVEL_MAX         = 6'h32;
  localparam logic       REF_RANGE_RESET       = 1'b1;

  // one set-point copy of the per-set-point settings
  typedef struct packed {
    logic [2:0] cmd_term;    // command-bus termination code
    logic [2:0] data_term;   // data-bus termination code
    logic       ref_range;   // reference range select
    logic [5:0] ref_level;   // reference level code
  } set_point_t;

  // one mode-register command
  typedef struct packed {
    logic       write;       // write command
    logic       read;        // read command
    logic [5:0] addr;        // mode address
    logic [7:0] data;        // operand
  } mr_cmd_t;

endpackage : mode_regs_pkg

//--- src/set_point_bank.sv
// Purpose: two set-point copies of termination and reference settings
// Assumes: write strobes already qualified by address
// Notes:   only the selected copy is written; the other holds
`timescale 1ns/10ps
`default_nettype none
module set_point_bank
  import mode_regs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // write side
  input  wire logic       sel_i,
  input  wire logic       term_we_i,
  input  wire logic       ref_we_i,
  input  wire logic [7:0] wdata_i,
  // copies
  output set_point_t      copy0_o,
  output set_point_t      copy1_o
);

  set_point_t copy_q [2];  // both copies

  // reset default of one copy
  function automatic set_point_t reset_copy();
    set_point_t c;
    c.cmd_term  = TERM_RESET;
    c.data_term = TERM_RESET;
    c.ref_range = REF_RANGE_RESET;
    c.ref_level = REF_LEVEL_RESET;
    return c;
  endfunction

  // selected copy only takes the write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      copy_q[0] <= reset_copy();
      copy_q[1] <= reset_copy();
    end else begin
      if (term_we_i) begin
        copy_q[sel_i].data_term <= wdata_i[DATA_TERM_LSB +: 3];
        copy_q[sel_i].cmd_term  <= wdata_i[CMD_TERM_LSB +: 3];
      end
      if (ref_we_i) begin
        copy_q[sel_i].ref_level <= wdata_i[REF_LEVEL_LSB +: 6];
        copy_q[sel_i].ref_range <= wdata_i[REF_RANGE_BIT];
      end
    end
  end

  assign copy0_o = copy_q[0];
  assign copy1_o = copy_q[1];

endmodule // set_point_bank
`default_nettype wire

//--- verification/mr_controller_model.sv
// Purpose: memory controller model issuing mode register writes and reads
// Assumes: one command at a time, strobes held for one cycle
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module mr_controller_model
  import mode_regs_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // command out
  output mr_cmd_t         cmd_o,
  // read answer in
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  // idle bus at time zero
  initial begin
    cmd_o = '{1'b0, 1'b0, 6'h3f, 8'hff};
  end

  // one command: drive after an edge, taken at the next, answer sampled just after
  task automatic issue(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic rv);
    @(posedge clk_i);
    #2;
    cmd_o = '{w, r, a, d};  // whole byte, level and range together
    @(posedge clk_i);
    #2;
    rd = rdata_i;
    rv = rvalid_i;
    cmd_o = '{1'b0, 1'b0, ~a, ~d};  // released lines do not keep the old value
  endtask
endmodule // mr_controller_model
`default_nettype wire

//--- verification/test_dram_mode_regs_7_to_12.sv
// Purpose: self-checking bench for the mode register bank 07h..0Ch
// Assumes: controller model issues commands, bench drives set-point selects and strap
// Notes:   random settings come from an lfsr seeded at 85
`timescale 1ns/10ps
`default_nettype none
module test_dram_mode_regs_7_to_12
  import mode_regs_pkg::*;
;
  localparam logic [7:0] REV_ID = 8'h5a;  // arbitrary value
  logic       clk     = 1'b0;  // bench clock
  logic       reset_n = 1'b0;  // active-low reset
  logic       wsel    = 1'b0;  // write set-point select
  logic       osel    = 1'b0;  // operating set-point select
  logic       strap   = 1'b0;  // calibration pin grounded
  mr_cmd_t    cmd;             // command from controller model
  logic [7:0] rdata, rd, rnd, tt;
  logic       rvalid, restore, cal_only, range_sel, rv;
  logic [2:0] dterm, cterm;
  logic [5:0] level;
  logic [7:0] term_m [2];      // expected 0Bh per copy
  logic [7:0] ref_m  [2];      // expected 0Ch per copy
  int         bad_count   = 0;
  int         check_count = 0;
  int         cycles      = 0;

  dram_mode_regs_7_to_12 #(.REVISION_ID_TWO(REV_ID)) u_dram_mode_regs_7_to_12 (
    .clk_i(clk), .reset_n_i(reset_n), .mr_write_i(cmd.write), .mr_read_i(cmd.read),
    .mr_addr_i(cmd.addr), .mr_wdata_i(cmd.data), .write_set_point_sel_i(wsel),
    .operating_set_point_sel_i(osel), .cal_pin_grounded_i(strap), .mr_rdata_o(rdata),
    .mr_rvalid_o(rvalid), .data_bus_termination_o(dterm), .cmd_bus_termination_o(cterm),
    .cmd_bus_reference_level_o(level), .cmd_reference_range_sel_o(range_sel),
    .calibration_default_restore_o(restore), .cal_default_only_o(cal_only));

  mr_controller_model u_mr_controller_model (
    .clk_i(clk), .cmd_o(cmd), .rdata_i(rdata), .rvalid_i(rvalid));

  // clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("Error at %0t: run did not finish", $time);
      finish_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // legal termination byte, reserved code folded away
  function automatic logic [7:0] term_code(input logic [7:0] r);
    return {1'b0, (r[6:4] == 3'h7) ? 3'h6 : r[6:4], 1'b0, (r[2:0] == 3'h7) ? 3'h1 : r[2:0]};
  endfunction
  // legal reference byte, level kept at or below 110010b
  function automatic logic [7:0] ref_code(input logic [7:0] r);
    return {1'b0, r[7], (r[5:0] > 6'h32) ? r[5:0] - 6'h32 : r[5:0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    u_mr_controller_model.issue(w, r, a, d, rd, rv);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    send(1'b0, 1'b1, a, 8'h00);
    chk({7'h00, rv}, 8'h01, "read valid");
    chk(rd, exp, "read data");
  endtask
  // active outputs follow the operating copy
  task automatic check_active();
    chk({1'b0, cterm, 1'b0, dterm}, term_m[osel], "terminations");
    chk({1'b0, range_sel, level}, ref_m[osel], "reference");
  endtask
  task automatic setp(input logic w, input logic o, input logic [7:0] t, input logic [7:0] r);
    wsel = w;
    osel = o;
    send(1'b1, 1'b0, ADDR_TERMINATION_SEL, t);
    term_m[w] = t;
    send(1'b1, 1'b0, ADDR_CMD_BUS_REF, r);
    ref_m[w] = r;
    check_active();
    rd_chk(ADDR_CMD_BUS_REF, ref_m[w]);
  endtask
  // reset, then defaults and caught strap
  task automatic do_reset();
    reset_n = 1'b0;
    term_m = '{8'h00, 8'h00};
    ref_m = '{8'h4d, 8'h4d};
    repeat (8) @(posedge clk);
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    check_active();
    chk({6'h00, rvalid, restore}, 8'h00, "idle pulses");
    chk({7'h00, cal_only}, {7'h00, strap}, "default-only flag");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rnd = 8'h55;
    do_reset();
    rd_chk(ADDR_REVISION_ID_TWO, REV_ID);
    rd_chk(ADDR_DEVICE_ORG, 8'h00);
    send(1'b1, 1'b0, ADDR_REVISION_ID_TWO, 8'hff);
    send(1'b1, 1'b0, ADDR_DEVICE_ORG, 8'hff);
    rd_chk(ADDR_REVISION_ID_TWO, REV_ID);
    rd_chk(ADDR_DEVICE_ORG, 8'h00);
    rd_chk(ADDR_CAL_RESET_CTRL, 8'h00);
    rd_chk(ADDR_TERMINATION_SEL, 8'h00);
    rd_chk(6'h09, 8'h00);
    $display("read-only test done");
    send(1'b1, 1'b0, ADDR_CAL_RESET_CTRL, 8'h01);
    chk({7'h00, restore}, 8'h01, "restore pulse");
    send(1'b1, 1'b0, ADDR_CAL_RESET_CTRL, 8'hfe);
    chk({7'h00, restore}, 8'h00, "no restore");
    $display("restore test done");
    setp(1'b0, 1'b0, 8'h66, 8'h32);
    setp(1'b1, 1'b0, 8'h11, 8'h40);
    setp(1'b1, 1'b1, 8'h00, 8'h00);
    repeat (40) begin
      rnd = lfsr(rnd);
      tt = term_code(rnd);
      rnd = lfsr(rnd);
      setp(rnd[0], rnd[1], tt, ref_code(rnd));
    end
    $display("set-point test done");
    strap = 1'b1;
    do_reset();
    send(1'b1, 1'b0, ADDR_CAL_RESET_CTRL, 8'h01);
    chk({7'h00, restore}, 8'h00, "restore with strap");
    $display("strap test done");
    finish_test();
  end
endmodule // test_dram_mode_regs_7_to_12
`default_nettype wire
